// ===== design/match_capture_timer.sv
// prescaled timer with three match and two capture channels
// assumes all control ports synchronous to mclk, held by software
//
// Notes on behaviour
// - peripheral clock through prescaler advances count
// - 32-bit count advanced only by prescaler
// - three 32-bit compares against count
// - per-match optional interrupt request
// - per-match action: run, stop, clear
// - two captures latch count on transition
// - capture interrupt optional and separate
// - timer mode and counter mode selectable
// - debug pause holds prescaler and count
`timescale 1ns/1ps
`include "tmr_map.svh"
module match_capture_timer #(
    parameter int PRE_W = `TMR_PRE_W,
    parameter int CNT_W = `TMR_CNT_W,
    parameter int NM    = `TMR_NUM_MATCH,
    parameter int NC    = `TMR_NUM_CAP
) (
    // clock and reset
    input  wire logic                mclk,
    input  wire logic                rst,
    // control
    input  wire logic                enable,
    input  wire logic                cnt_reset,
    input  wire tmr_pkg::cnt_mode_e  mode,
    input  wire logic                cnt_in,
    input  wire logic [PRE_W-1:0]    pre_term,
    input  wire logic                pause_en,
    input  wire logic                core_debug,
    // match configuration
    input  wire logic [NM*CNT_W-1:0] match_val,
    input  wire logic [NM-1:0]       match_int_en,
    input  wire logic [NM*2-1:0]     match_act,
    // capture configuration
    input  wire logic [NC-1:0]       cap_in,
    input  wire logic [NC*2-1:0]     cap_edge,
    input  wire logic [NC-1:0]       cap_int_en,
    // status
    output logic [CNT_W-1:0]         count,
    output logic [PRE_W-1:0]         prescale,
    output logic                     running,
    output logic [NM-1:0]            match_irq,
    output logic [NC*CNT_W-1:0]      cap_val,
    output logic [NC-1:0]            cap_irq
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    // one record, so reset and update always stay in step
    typedef struct packed {
        tmr_pkg::run_st_e  run;     // run state
        logic [PRE_W-1:0]  pre;     // prescale counter
        logic [CNT_W-1:0]  cnt;     // main count
        logic              in_d;    // last counter input
        logic [NM-1:0]     hit_d;   // equality seen last cycle
        logic [NM-1:0]     irq;     // match pulses
    } tmr_s;
    tmr_s st_r;
    tmr_s st_nxt;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    // one combinational pass builds the whole next state
    logic          tick;      // advance strobe for main count
    logic          hold;      // pause or not running
    logic [NM-1:0] eq;        // raw equality
    logic [NM-1:0] fresh;     // first cycle of equality
    logic          do_stop;
    logic          do_clear;

    always_comb begin
        st_nxt = st_r;
        tick = 1'b0;
        do_stop = 1'b0;
        do_clear = 1'b0;
        hold = (st_r.run != tmr_pkg::st_run) | (pause_en & core_debug);
        // matches are still compared while held; only counting stops
        // run state follows enable; stop sticks until disabled
        case (st_r.run)
            tmr_pkg::st_idle: begin
                if (enable) begin
                    st_nxt.run = tmr_pkg::st_run;
                end
            end
            tmr_pkg::st_run: begin
                if (!enable) begin
                    st_nxt.run = tmr_pkg::st_idle;
                end
            end
            tmr_pkg::st_stopped: begin
                if (!enable) begin
                    st_nxt.run = tmr_pkg::st_idle;
                end
            end
            default: begin
                // unused code falls back to idle
                st_nxt.run = tmr_pkg::st_idle;
            end
        endcase
        // counter input delayed one cycle for edge detection
        st_nxt.in_d = cnt_in;
        // a terminal lowered below the prescale wraps at once
        if (!hold) begin
            if (st_r.pre >= pre_term) begin
                st_nxt.pre = '0;
                tick = 1'b1;
            end else begin
                st_nxt.pre = st_r.pre + 1'b1;
            end
        end
        if (mode == tmr_pkg::mode_counter) begin
            // counter mode: prescaler divides rising input edges
            // a level held high counts once, on its rising edge
            if (!hold) begin
                st_nxt.pre = st_r.pre;
                if (cnt_in & ~st_r.in_d) begin
                    if (st_r.pre >= pre_term) begin
                        st_nxt.pre = '0;
                    end else begin
                        st_nxt.pre = st_r.pre + 1'b1;
                    end
                end
            end
            tick = !hold && cnt_in && !st_r.in_d && (st_r.pre >= pre_term);
        end
        if (tick) begin
            st_nxt.cnt = st_r.cnt + 1'b1;
        end
        // compare values may change at any time; no shadow copy
        // continuous compare
        for (int i = 0; i < NM; i++) begin
            eq[i] = (st_r.cnt == match_val[i*CNT_W +: CNT_W]);
        end
        // a compare value written equal to a held count fires once
        // once per equality
        fresh = eq & ~st_r.hit_d;
        st_nxt.hit_d = eq;
        for (int i = 0; i < NM; i++) begin
            if (fresh[i]) begin
                if (match_act[i*2 +: 2] == tmr_pkg::act_stop) begin
                    do_stop = 1'b1;
                end
                if (match_act[i*2 +: 2] == tmr_pkg::act_clear) begin
                    do_clear = 1'b1;
                end
            end
        end
        st_nxt.irq = fresh & match_int_en;
        // stop freezes count at the matched value
        // the tick of the matching edge is dropped, else the count
        // would stop one past the compare value
        if (do_stop && st_r.run == tmr_pkg::st_run) begin
            st_nxt.run = tmr_pkg::st_stopped;
            st_nxt.cnt = st_r.cnt;
            st_nxt.pre = st_r.pre;
        end
        // clear wins over stop so a stopped count still reads zero
        if (do_clear) begin
            st_nxt.cnt = '0;
            st_nxt.pre = '0;
        end
        // software reset of count and prescaler; level sensitive,
        // so the count stays at zero while it is held high
        if (cnt_reset) begin
            st_nxt.cnt = '0;
            st_nxt.pre = '0;
        end
    end

    // register the whole state
    // async reset so outputs are defined before the first clock
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_r.run <= tmr_pkg::st_idle;
            st_r.pre <= `TMR_PRE_RST;
            st_r.cnt <= `TMR_CNT_RST;
            st_r.in_d <= 1'b0;
            st_r.hit_d <= '0;
            st_r.irq <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------
    // capture channels
    // ----------------------------------------
    // captures snoop the count whether or not it is running
    // each channel sees the registered count, so a snapshot
    // shows the value that stood at the sampled input edge
    for (genvar c = 0; c < NC; c++) begin : g_cap
        tmr_capture #(
            .CNT_W (CNT_W)
        ) u_cap (
            .mclk     (mclk),
            .rst      (rst),
            .edge_sel (cap_edge[c*2 +: 2]),
            .int_en   (cap_int_en[c]),
            .cap_in   (cap_in[c]),
            .count    (st_r.cnt),
            .cap_val  (cap_val[c*CNT_W +: CNT_W]),
            .cap_irq  (cap_irq[c])
        );
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign count = st_r.cnt;
    assign prescale = st_r.pre;
    assign running = (st_r.run == tmr_pkg::st_run);
    assign match_irq = st_r.irq;
endmodule

// ===== design/tmr_map.svh
// constants for the prescaled match/capture timer
// assumes inclusion by bare name from package and modules
`ifndef TMR_MAP_SVH
`define TMR_MAP_SVH
// ----------------------------------------
// widths and reset values
// ----------------------------------------
`define TMR_PRE_W      16
`define TMR_CNT_W      32
`define TMR_NUM_MATCH  3
`define TMR_NUM_CAP    2
`define TMR_CNT_RST    32'h0000_0000
`define TMR_PRE_RST    16'h0000
// ----------------------------------------
// capture edge select field positions
// ----------------------------------------
`define TMR_EDGE_RISE  0
`define TMR_EDGE_FALL  1
`endif

// ===== design/tmr_pkg.sv
// types shared by the timer modules
// assumes tmr_map.svh sits beside it
`include "tmr_map.svh"
package tmr_pkg;
    // action on a match
    typedef enum logic [1:0] {
        act_run   = 2'b00,
        act_stop  = 2'b01,
        act_clear = 2'b11
    } match_act_e;
    // timer counts prescaled clock, counter counts input edges
    typedef enum logic {
        mode_timer   = 1'b0,
        mode_counter = 1'b1
    } cnt_mode_e;
    // run state, gray along idle -> running -> stopped
    typedef enum logic [1:0] {
        st_idle    = 2'b00,
        st_run     = 2'b01,
        st_stopped = 2'b11
    } run_st_e;
endpackage

// ===== design/tmr_capture.sv
// one capture channel: edge detect and snapshot of the count
// assumes inputs synchronous to mclk
`timescale 1ns/1ps
`include "tmr_map.svh"
module tmr_capture #(
    parameter int CNT_W = `TMR_CNT_W
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             rst,
    // control
    input  wire logic [1:0]       edge_sel,
    input  wire logic             int_en,
    // signal and count
    input  wire logic             cap_in,
    input  wire logic [CNT_W-1:0] count,
    // results
    output logic [CNT_W-1:0]      cap_val,
    output logic                  cap_irq
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic             prev;  // last input level
        logic [CNT_W-1:0] val;   // snapshot
        logic             irq;   // one-cycle event
    } cap_s;
    cap_s st_r;
    cap_s st_nxt;
    logic rise;
    logic fall;
    logic hit;

    // next state
    always_comb begin
        rise = cap_in & ~st_r.prev;
        fall = ~cap_in & st_r.prev;
        hit = (rise & edge_sel[`TMR_EDGE_RISE])
            | (fall & edge_sel[`TMR_EDGE_FALL]);
        st_nxt = st_r;
        st_nxt.prev = cap_in;
        if (hit) begin
            st_nxt.val = count;
        end
        st_nxt.irq = hit & int_en;
    end

    // register; prev starts low so an input high at reset is a rise
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign cap_val = st_r.val;
    assign cap_irq = st_r.irq;
endmodule

// ===== tb/mct_asserts.sv
// port-level checks for match_capture_timer
// assumes bound into every match_capture_timer instance
`timescale 1ns/1ps
module mct_asserts #(
    parameter int PRE_W = 16,
    parameter int CNT_W = 32,
    parameter int NM    = 3,
    parameter int NC    = 2
) (
    // clock and reset
    input wire logic                mclk,
    input wire logic                rst,
    // control
    input wire logic                enable,
    input wire logic                cnt_reset,
    input wire tmr_pkg::cnt_mode_e  mode,
    input wire logic [PRE_W-1:0]    pre_term,
    input wire logic                pause_en,
    input wire logic                core_debug,
    // match configuration
    input wire logic [NM*CNT_W-1:0] match_val,
    input wire logic [NM-1:0]       match_int_en,
    input wire logic [NM*2-1:0]     match_act,
    // capture configuration
    input wire logic [NC-1:0]       cap_in,
    input wire logic [NC*2-1:0]     cap_edge,
    input wire logic [NC-1:0]       cap_int_en,
    // status
    input wire logic [CNT_W-1:0]    count,
    input wire logic [PRE_W-1:0]    prescale,
    input wire logic                running,
    input wire logic [NM-1:0]       match_irq,
    input wire logic [NC*CNT_W-1:0] cap_val,
    input wire logic [NC-1:0]       cap_irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // channels whose match would stop or clear the count
    logic [NM-1:0] halt;
    always_comb
        for (int i = 0; i < NM; i++)
            halt[i] = count == match_val[i*CNT_W+:CNT_W] && match_act[2*i];
    wire pz = pause_en && core_debug;
    wire qt = !cnt_reset && !(|halt);
    wire e0 = count == match_val[CNT_W-1:0];
    wire e1 = count == match_val[2*CNT_W-1:CNT_W];
    a_pause_hold: assert property (pz && qt |=>
        $stable(count) && $stable(prescale)) else $error("pause moved");
    a_idle_hold: assert property (!running && qt |=>
        $stable(count) && $stable(prescale)) else $error("idle moved");
    a_tick_adv: assert property (running && enable && !pz && qt &&
        mode == tmr_pkg::mode_timer |=> count == $past(count) +
        ($past(prescale) == $past(pre_term)) && prescale == ($past(prescale)
        == $past(pre_term) ? '0 : $past(prescale) + 1'b1))
        else $error("bad prescale step");
    a_cnt_zero: assert property (cnt_reset |=> count == '0 &&
        prescale == '0) else $error("reset of count missed");
    a_irq_rise: assert property ($rose(e0) && match_int_en[0]
        |=> match_irq[0]) else $error("match irq missing");
    a_irq_cause: assert property (match_irq[0] |->
        $past(e0 && match_int_en[0])) else $error("stray match irq");
    a_irq_once: assert property (match_irq[0] |=> !match_irq[0])
        else $error("match irq repeated");
    a_stop_act: assert property ($rose(e1) &&
        match_act[3:2] == 2'b01 && running && enable && !cnt_reset
        |=> !running && (count == $past(count) || count == '0))
        else $error("no stop");
    a_clear_act: assert property ($rose(e0) && match_act[1:0] == 2'b11
        && running && enable && !pz |=> count == '0) else $error("no clear");
    a_cap_rise: assert property (!$past(rst) && $rose(cap_in[0]) &&
        cap_edge[0] |=> cap_val[CNT_W-1:0] == $past(count) &&
        cap_irq[0] == $past(cap_int_en[0])) else $error("capture 0 bad");
    a_cap_fall: assert property (!$past(rst) && $fell(cap_in[1]) &&
        cap_edge[3] |=> cap_val[2*CNT_W-1:CNT_W] == $past(count))
        else $error("capture 1 bad");
    a_cap_irq: assert property (cap_irq[1] |-> $past(cap_int_en[1]))
        else $error("stray capture irq");
endmodule
bind match_capture_timer mct_asserts #(.PRE_W(PRE_W), .CNT_W(CNT_W),
    .NM(NM), .NC(NC)) i_mct_asserts (
    .mclk         (mclk),
    .rst          (rst),
    .enable       (enable),
    .cnt_reset    (cnt_reset),
    .mode         (mode),
    .pre_term     (pre_term),
    .pause_en     (pause_en),
    .core_debug   (core_debug),
    .match_val    (match_val),
    .match_int_en (match_int_en),
    .match_act    (match_act),
    .cap_in       (cap_in),
    .cap_edge     (cap_edge),
    .cap_int_en   (cap_int_en),
    .count        (count),
    .prescale     (prescale),
    .running      (running),
    .match_irq    (match_irq),
    .cap_val      (cap_val),
    .cap_irq      (cap_irq)
);

// ===== tb/tb.sv
// self-checking bench for match_capture_timer
// assumes the design files compiled first
`timescale 1ns/1ps
module tb;
    logic mclk, rst, enable, cnt_reset, cnt_in, pause_en, core_debug;
    logic running;
    tmr_pkg::cnt_mode_e mode;
    logic [15:0] pre_term, prescale;
    logic [95:0] match_val;
    logic [5:0]  match_act;
    logic [2:0]  match_int_en, match_irq;
    logic [1:0]  cap_in, cap_int_en, cap_irq;
    logic [3:0]  cap_edge;
    logic [31:0] count, c;
    logic [63:0] cap_val;
    int          err_count, comparisons;
    match_capture_timer i_match_capture_timer (
        .mclk         (mclk),
        .rst          (rst),
        .enable       (enable),
        .cnt_reset    (cnt_reset),
        .mode         (mode),
        .cnt_in       (cnt_in),
        .pre_term     (pre_term),
        .pause_en     (pause_en),
        .core_debug   (core_debug),
        .match_val    (match_val),
        .match_int_en (match_int_en),
        .match_act    (match_act),
        .cap_in       (cap_in),
        .cap_edge     (cap_edge),
        .cap_int_en   (cap_int_en),
        .count        (count),
        .prescale     (prescale),
        .running      (running),
        .match_irq    (match_irq),
        .cap_val      (cap_val),
        .cap_irq      (cap_irq)
    );
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // start counting, bounded wait for running
    task automatic go;
        enable = 1'b1;
        for (int i = 0; i < 8 && running !== 1'b1; i++)
            cyc(1);
        chk(running, 1);
    endtask
    // back to idle with count zeroed
    task automatic idle;
        enable = 1'b0;
        cnt_reset = 1'b1;
        cyc(1);
        chk(count, 0);
        chk(prescale, 0);
        cnt_reset = 1'b0;
    endtask
    task automatic t_clear;
        match_val = {32'h0000_0001, 32'hffff_ffff, 32'h0000_0002};
        match_act = 6'b00_00_11;
        match_int_en = 3'b101;
        go();
        chk(count, 0);
        cyc(1);
        chk(count, 1);
        cyc(1);
        chk({match_irq, count}, {3'b100, 32'h0000_0002});
        cyc(1);
        chk({match_irq, count}, {3'b001, 32'h0000_0000});
        cyc(1);
        chk({match_irq, count}, {3'b000, 32'h0000_0001});
        idle();
    endtask
    task automatic t_stop;
        match_val = {32'h0000_0001, 32'h0000_0002, 32'h0000_0002};
        match_act = 6'b00_01_00;
        match_int_en = 3'b010;
        go();
        cyc(2);
        chk({match_irq, count}, {3'b000, 32'h0000_0002});
        cyc(1);
        chk({running, match_irq}, 4'b0010);
        cyc(3);
        chk({running, match_irq, count}, {4'b0000, 32'h0000_0002});
        idle();
    endtask
    task automatic t_pre;
        match_act = 6'b00_00_00;
        pre_term = 16'h0002;
        go();
        for (int k = 0; k < 6; k++) begin
            chk({prescale, count}, {16'(k % 3), 32'(k / 3)});
            cyc(1);
        end
        pause_en = 1'b1;
        core_debug = 1'b1;
        cyc(4);
        chk({prescale, count}, {16'h0000, 32'h0000_0002});
        core_debug = 1'b0;
        cyc(1);
        chk(prescale, 1);
        // debug state alone, with pause off, keeps counting
        pause_en = 1'b0;
        core_debug = 1'b1;
        cyc(1);
        chk(prescale, 2);
        core_debug = 1'b0;
    endtask
    task automatic t_cap;
        cap_edge = 4'b10_01;
        cap_int_en = 2'b01;
        cap_in = 2'b10;
        cyc(2);
        chk({cap_irq, cap_val}, 0);
        c = count;
        cap_in = 2'b01;
        cyc(1);
        chk({cap_irq, cap_val}, {2'b01, c, c});
        cyc(1);
        chk(cap_irq, 0);
        idle();
    endtask
    task automatic t_cnt;
        mode = tmr_pkg::mode_counter;
        pre_term = 16'h0000;
        go();
        repeat (3) begin
            cnt_in = 1'b1;
            cyc(1);
            cnt_in = 1'b0;
            cyc(1);
        end
        cyc(2);
        chk(count, 3);
    endtask
    // mid-run reset clears all outputs; a high capture input
    // seen after release counts as a rise
    task automatic t_rst;
        rst = 1'b1;
        cyc(1);
        chk({count, prescale, running}, 0);
        chk({match_irq, cap_val, cap_irq}, 0);
        rst = 1'b0;
        cyc(1);
        chk({running, cap_irq, count}, {1'b1, 2'b01, 32'h0000_0000});
    endtask
    task automatic summarize;
        if (err_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // watchdog, far beyond the 46 cycles used
    initial begin
        repeat (2000) @(posedge mclk);
        err_count++;
        summarize();
    end
    initial begin
        {enable, cnt_reset, cnt_in, pause_en, core_debug} = '0;
        mode = tmr_pkg::mode_timer;
        {pre_term, match_val, match_act, match_int_en} = '0;
        {cap_in, cap_edge, cap_int_en} = '0;
        rst = 1'b1;
        cyc(3);
        rst = 1'b0;
        t_clear();
        t_stop();
        t_pre();
        t_cap();
        t_cnt();
        t_rst();
        summarize();
    end
endmodule
